/* File: hdl/exc_guard_map.svh */
// Constants for the request checker and password guard
// Operation
// [RULE1] Good processable request gets normal response
// [RULE2] Missing or corrupt request gets no answer
// [RULE3] Unprocessable good request gets exception frame
// [RULE4] Frame: slave, function, code, two CRC bytes
// [RULE5] Exception function is request function plus 0x80
// [RULE6] Slave number lies within 1 to 247
// [RULE7] CRC16 appended over whole exception frame
// [RULE8] Code 0x01 for illegal function or state
// [RULE9] Code 0x02 for illegal data address
// [RULE10] Code 0x03 for illegal data value
// [RULE11] Code 0x04 for internal device failure
// [RULE12] Code 0x05 for long acknowledged processing
// [RULE13] Code 0x06 while busy; master retries later
// [RULE14] Code 0x07 when programming request impossible
// [RULE15] Codes 0x08, 0x0A, 0x0B for listed faults
// [RULE16] Register absent in old firmware gives 0x02
// [RULE17] Unprotected modification rejected and not executed
// [RULE18] Hardware lock always overrides password check; the code sees the pad two clocks after it moves
// [RULE19] Intrusive command needs matching profile password
// [RULE20] Non-intrusive commands need no password
// [RULE21] Reset passwords are repeated ASCII digits
// [RULE22] Password is four letters or digits only
// [RULE23] Change needs own or administrator password
// [RULE24] Count each exception and bad broadcast
// [RULE25] Exception code is one byte before CRC
`ifndef EXC_GUARD_MAP_SVH
`define EXC_GUARD_MAP_SVH
`define EXC_ILL_FUNC 8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_VALUE 8'h03
`define EXC_DEV_FAIL 8'h04
`define EXC_ACK 8'h05
`define EXC_BUSY 8'h06
`define EXC_NAK 8'h07
`define EXC_PARITY 8'h08
`define EXC_GW_PATH 8'h0A
`define EXC_GW_TARGET 8'h0B
`define EXC_FUNC_FLAG 8'h80
`define SLAVE_MIN 8'h01
`define SLAVE_MAX 8'hF7
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define PW_ADMIN 32'h30303030
`define PW_SERVICES 32'h31313131
`define PW_ENGINEER 32'h32323232
`define PW_OPERATOR 32'h33333333
`define PROF_ADMIN 2'h0
`define CNT_MAX 16'hFFFF
`endif

/* File: hdl/exc_guard_pkg.sv */
// Types for the request checker and password guard
package exc_guard_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_CRC_LO, ST_CRC_HI} tx_state_t;
    typedef enum logic [1:0] {VERDICT_NONE, VERDICT_NORMAL, VERDICT_EXC} verdict_t;
endpackage

/* File: hdl/modbus_exception_and_password_guard.sv */
// Request verdict, exception framer, password guard and exception counter
`timescale 1ns/1ps
`include "exc_guard_map.svh"
module modbus_exception_and_password_guard
    import exc_guard_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_COMM_ERR_I,
    input wire logic REQ_BROADCAST_I,
    input wire logic [7:0] REQ_SLAVE_I,
    input wire logic [7:0] REQ_FUNC_I,
    input wire logic FLT_ILL_FUNC_I,
    input wire logic FLT_ILL_ADDR_I,
    input wire logic FLT_REG_ABSENT_I,
    input wire logic FLT_ILL_VALUE_I,
    input wire logic FLT_DEV_FAIL_I,
    input wire logic FLT_LONG_I,
    input wire logic FLT_BUSY_I,
    input wire logic FLT_PROG_I,
    input wire logic FLT_PARITY_I,
    input wire logic FLT_GW_PATH_I,
    input wire logic FLT_GW_TARGET_I,
    input wire logic CMD_VALID_I,
    input wire logic CMD_VIA_IFACE_I,
    input wire logic CMD_INTRUSIVE_I,
    input wire logic [3:0] CMD_PROFILES_I,
    input wire logic [31:0] CMD_PASSWORD_I,
    input wire logic HW_UNLOCKED_I,
    input wire logic PWC_VALID_I,
    input wire logic [1:0] PWC_PROFILE_I,
    input wire logic [31:0] PWC_AUTH_I,
    input wire logic [31:0] PWC_NEW_I,
    input wire logic CNT_CLEAR_I,
    input wire logic TX_READY_I,
    output logic NORMAL_RESP_O,
    output logic EXC_BUSY_O,
    output logic TX_VALID_O,
    output logic [7:0] TX_DATA_O,
    output logic TX_LAST_O,
    output logic CMD_EXEC_O,
    output logic CMD_REJECT_O,
    output logic PWC_DONE_O,
    output logic PWC_ERR_O,
    output logic [15:0] EXC_COUNT_O
);

    // ----------------------------------------
    // Password character check
    // ----------------------------------------
    function automatic logic char_ok(input logic [7:0] c);
        char_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A)
            || (c >= 8'h61 && c <= 8'h7A);
    endfunction

    // ----------------------------------------
    // Modbus CRC16 step, low bit first
    // ----------------------------------------
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        // Bit-serial loop; becomes eight xor stages in logic
        c = crc ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        crc_byte = c;
    endfunction

    // ----------------------------------------
    // Request verdict
    // ----------------------------------------
    logic [7:0] exc_code;
    logic any_fault;
    logic slave_ok;
    logic req_take;
    logic tx_idle;

    always_comb
    begin
        exc_code = `EXC_ILL_FUNC;
        any_fault = 1'b1;
        // Priority: function first, then address, value, then parity, then device state, then gateway faults, with long processing last
        if (FLT_ILL_FUNC_I)
            exc_code = `EXC_ILL_FUNC; // [RULE8]
        else if (FLT_ILL_ADDR_I || FLT_REG_ABSENT_I)
            exc_code = `EXC_ILL_ADDR; // [RULE9] [RULE16]
        else if (FLT_ILL_VALUE_I)
            exc_code = `EXC_ILL_VALUE; // [RULE10]
        else if (FLT_PARITY_I)
            exc_code = `EXC_PARITY; // [RULE15]
        else if (FLT_DEV_FAIL_I)
            exc_code = `EXC_DEV_FAIL; // [RULE11]
        else if (FLT_BUSY_I)
            exc_code = `EXC_BUSY; // [RULE13]
        else if (FLT_PROG_I)
            exc_code = `EXC_NAK; // [RULE14]
        else if (FLT_GW_PATH_I)
            exc_code = `EXC_GW_PATH; // [RULE15]
        else if (FLT_GW_TARGET_I)
            exc_code = `EXC_GW_TARGET; // [RULE15]
        else if (FLT_LONG_I)
            exc_code = `EXC_ACK; // [RULE12]
        else
            any_fault = 1'b0;
    end

    assign slave_ok = (REQ_SLAVE_I >= `SLAVE_MIN) && (REQ_SLAVE_I <= `SLAVE_MAX); // [RULE6]
    // A request arriving while a frame is still going out is dropped
    assign req_take = REQ_VALID_I && tx_idle;

    verdict_t verdict;
    always_comb
    begin
        if (!req_take || REQ_COMM_ERR_I)
            verdict = VERDICT_NONE; // [RULE2]
        // Out-of-range slave numbers are not for us
        else if (REQ_BROADCAST_I || !slave_ok)
            verdict = VERDICT_NONE; // [RULE2]
        else if (any_fault)
            verdict = VERDICT_EXC; // [RULE3]
        else
            verdict = VERDICT_NORMAL; // [RULE1]
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            NORMAL_RESP_O <= 1'b0;
        else
            NORMAL_RESP_O <= (verdict == VERDICT_NORMAL); // [RULE1]
    end

    // ----------------------------------------
    // Exception framer
    // ----------------------------------------
    tx_state_t state_r;
    logic [1:0] idx_r;
    logic [7:0] fr_slave_r;
    logic [7:0] fr_func_r;
    logic [7:0] fr_code_r;
    logic [15:0] crc_r;
    logic [7:0] cur_byte;
    logic tx_fire;
    logic [15:0] crc_next;

    assign tx_idle = (state_r == ST_IDLE);
    assign tx_fire = TX_VALID_O && TX_READY_I;
    // One CRC step shared by the register and the low check byte
    assign crc_next = crc_byte(crc_r, cur_byte);

    always_comb
    begin
        unique case (idx_r)
            2'h0: cur_byte = fr_slave_r;
            2'h1: cur_byte = fr_func_r;
            default: cur_byte = fr_code_r; // [RULE25]
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            state_r <= ST_IDLE;
            idx_r <= 2'h0;
            fr_slave_r <= 8'h00;
            fr_func_r <= 8'h00;
            fr_code_r <= 8'h00;
            crc_r <= `CRC_INIT;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (verdict == VERDICT_EXC)
                    begin
                        fr_slave_r <= REQ_SLAVE_I; // [RULE4]
                        fr_func_r <= REQ_FUNC_I | `EXC_FUNC_FLAG; // [RULE5]
                        fr_code_r <= exc_code; // [RULE25]
                        idx_r <= 2'h0;
                        crc_r <= `CRC_INIT;
                        state_r <= ST_SEND;
                    end
                ST_SEND:
                    if (tx_fire)
                    begin
                        crc_r <= crc_next; // [RULE7]
                        idx_r <= idx_r + 2'h1;
                        if (idx_r == 2'h2)
                            state_r <= ST_CRC_LO;
                    end
                ST_CRC_LO:
                    if (tx_fire)
                        state_r <= ST_CRC_HI; // [RULE4]
                ST_CRC_HI:
                    if (tx_fire)
                        state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Framer outputs
    // ----------------------------------------
    // Data held in flops; valid is a state decode
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            TX_DATA_O <= 8'h00;
        else if (state_r == ST_IDLE && verdict == VERDICT_EXC)
            TX_DATA_O <= REQ_SLAVE_I;
        else if (state_r == ST_SEND && tx_fire && idx_r == 2'h0)
            TX_DATA_O <= fr_func_r;
        else if (state_r == ST_SEND && tx_fire && idx_r == 2'h1)
            TX_DATA_O <= fr_code_r;
        else if (state_r == ST_SEND && tx_fire)
            TX_DATA_O <= crc_next[7:0]; // [RULE7]
        else if (state_r == ST_CRC_LO && tx_fire)
            TX_DATA_O <= crc_r[15:8];
    end

    assign TX_VALID_O = !tx_idle;
    assign TX_LAST_O = (state_r == ST_CRC_HI);
    assign EXC_BUSY_O = !tx_idle;

    // ----------------------------------------
    // Exception counter
    // ----------------------------------------
    logic bad_bcast;
    // Broadcasts get no frame, but a faulty one still counts
    assign bad_bcast = req_take && !REQ_COMM_ERR_I && REQ_BROADCAST_I && any_fault;

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
            EXC_COUNT_O <= 16'h0000;
        else if (CNT_CLEAR_I)
            EXC_COUNT_O <= 16'h0000;
        else if ((verdict == VERDICT_EXC) || bad_bcast)
        begin
            // Wraps to zero at the top value
            if (EXC_COUNT_O == `CNT_MAX)
                EXC_COUNT_O <= 16'h0000;
            else
                EXC_COUNT_O <= EXC_COUNT_O + 16'h0001; // [RULE24]
        end
    end

    // ----------------------------------------
    // Lock pad synchroniser
    // ----------------------------------------
    logic unlock_meta_r;
    logic unlock_sync_r;

    // Both stages reset locked, so nothing intrusive slips through after reset
    // Limitation: the pad takes effect two clocks after it moves
    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            unlock_meta_r <= 1'b0;
            unlock_sync_r <= 1'b0;
        end
        else
        begin
            unlock_meta_r <= HW_UNLOCKED_I;
            unlock_sync_r <= unlock_meta_r; // [RULE18]
        end
    end

    // ----------------------------------------
    // Password store and command guard
    // ----------------------------------------
    logic [31:0] pw_r [4];
    logic [3:0] pw_match;
    logic cmd_ok;
    logic new_ok;
    logic auth_ok;

    always_comb
    begin
        for (int p = 0; p < 4; p++)
            pw_match[p] = CMD_PROFILES_I[p] && (CMD_PASSWORD_I == pw_r[p]); // [RULE19]
    end

    always_comb
    begin
        if (!CMD_VIA_IFACE_I)
            cmd_ok = 1'b0; // [RULE17]
        else if (!CMD_INTRUSIVE_I)
            cmd_ok = 1'b1; // [RULE20]
        // Lock is checked before any password: hardware wins
        else if (!unlock_sync_r)
            cmd_ok = 1'b0; // [RULE18]
        else
            cmd_ok = |pw_match; // [RULE19]
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            CMD_EXEC_O <= 1'b0;
            CMD_REJECT_O <= 1'b0;
        end
        else
        begin
            CMD_EXEC_O <= CMD_VALID_I && cmd_ok;
            CMD_REJECT_O <= CMD_VALID_I && !cmd_ok; // [RULE17]
        end
    end

    // ----------------------------------------
    // Password change
    // ----------------------------------------
    // Administrator password opens any profile
    assign new_ok = char_ok(PWC_NEW_I[31:24]) && char_ok(PWC_NEW_I[23:16])
        && char_ok(PWC_NEW_I[15:8]) && char_ok(PWC_NEW_I[7:0]); // [RULE22]
    assign auth_ok = (PWC_AUTH_I == pw_r[PWC_PROFILE_I])
        || (PWC_AUTH_I == pw_r[`PROF_ADMIN]); // [RULE23]

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            pw_r[0] <= `PW_ADMIN; // [RULE21]
            pw_r[1] <= `PW_SERVICES;
            pw_r[2] <= `PW_ENGINEER;
            pw_r[3] <= `PW_OPERATOR;
            PWC_DONE_O <= 1'b0;
            PWC_ERR_O <= 1'b0;
        end
        else
        begin
            PWC_DONE_O <= PWC_VALID_I && new_ok && auth_ok;
            PWC_ERR_O <= PWC_VALID_I && !(new_ok && auth_ok); // [RULE22]
            if (PWC_VALID_I && new_ok && auth_ok)
                pw_r[PWC_PROFILE_I] <= PWC_NEW_I; // [RULE23]
        end
    end

endmodule

/* File: tb/guard_monitor.sv */
// Port checks for the request checker and password guard
`timescale 1ns/1ps
module guard_monitor (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_COMM_ERR_I,
    input wire logic [7:0] REQ_SLAVE_I,
    input wire logic CMD_VALID_I,
    input wire logic CMD_VIA_IFACE_I,
    input wire logic CMD_INTRUSIVE_I,
    input wire logic HW_UNLOCKED_I,
    input wire logic TX_READY_I,
    input wire logic NORMAL_RESP_O,
    input wire logic TX_VALID_O,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_LAST_O,
    input wire logic CMD_EXEC_O,
    input wire logic CMD_REJECT_O,
    input wire logic [15:0] EXC_COUNT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    a_err_silent: assert property (REQ_VALID_I && REQ_COMM_ERR_I && !TX_VALID_O
        |=> !TX_VALID_O && !NORMAL_RESP_O) else $error("answer after corrupt request");
    a_normal_cause: assert property (NORMAL_RESP_O
        |-> $past(REQ_VALID_I) && !$past(REQ_COMM_ERR_I)) else $error("stray normal response");
    a_exc_cause: assert property ($rose(TX_VALID_O)
        |-> $past(REQ_VALID_I) && TX_DATA_O == $past(REQ_SLAVE_I)) else $error("bad frame start");
    a_tx_hold: assert property (TX_VALID_O && !TX_READY_I
        |=> TX_VALID_O && $stable(TX_DATA_O)) else $error("byte changed while stalled");
    a_frame_end: assert property (TX_VALID_O && TX_READY_I && TX_LAST_O
        |=> !TX_VALID_O) else $error("frame runs past last byte");
    a_count_step: assert property ($rose(TX_VALID_O)
        |-> EXC_COUNT_O == $past(EXC_COUNT_O) + 16'h0001) else $error("counter missed frame");
    a_cmd_path: assert property (CMD_VALID_I && !CMD_VIA_IFACE_I
        |=> CMD_REJECT_O && !CMD_EXEC_O) else $error("bypass command not rejected");
    // Lock pad reaches the guard through two sync stages
    a_hw_lock: assert property (CMD_VALID_I && CMD_VIA_IFACE_I && CMD_INTRUSIVE_I
        && !$past(HW_UNLOCKED_I, 2) |=> CMD_REJECT_O) else $error("lock ignored");
    a_free_cmd: assert property (CMD_VALID_I && CMD_VIA_IFACE_I && !CMD_INTRUSIVE_I
        |=> CMD_EXEC_O && !CMD_REJECT_O) else $error("plain command not run");
endmodule
bind modbus_exception_and_password_guard guard_monitor guard_monitor_inst (.CLK_I(CLK_I),
    .NRST_I(NRST_I), .REQ_VALID_I(REQ_VALID_I), .REQ_COMM_ERR_I(REQ_COMM_ERR_I),
    .REQ_SLAVE_I(REQ_SLAVE_I), .CMD_VALID_I(CMD_VALID_I), .CMD_VIA_IFACE_I(CMD_VIA_IFACE_I),
    .CMD_INTRUSIVE_I(CMD_INTRUSIVE_I), .HW_UNLOCKED_I(HW_UNLOCKED_I), .TX_READY_I(TX_READY_I),
    .NORMAL_RESP_O(NORMAL_RESP_O), .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O),
    .TX_LAST_O(TX_LAST_O), .CMD_EXEC_O(CMD_EXEC_O), .CMD_REJECT_O(CMD_REJECT_O),
    .EXC_COUNT_O(EXC_COUNT_O));

/* File: tb/bus_sink.sv */
// Bus master model taking exception frame bytes
`timescale 1ns/1ps
module bus_sink (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic stall_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic [7:0] rx_r [0:4];
    int n_r = 0;
    logic [15:0] crc_r = 16'hFFFF;
    logic [15:0] res_r = 16'hFFFF;
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction
    // Stalling toggles ready so held bytes get exercised
    always_ff @(posedge clk_i)
        tx_ready_o <= !nrst_i || !stall_i || !tx_ready_o;
    // Residue over a whole frame with its check bytes is zero
    always_ff @(posedge clk_i)
    begin
        if (tx_valid_i && tx_ready_o)
        begin
            rx_r[n_r % 5] <= tx_data_i;
            n_r <= n_r + 1;
            crc_r <= (n_r % 5 == 4) ? 16'hFFFF : crc_step(crc_r, tx_data_i);
            res_r <= crc_step(crc_r, tx_data_i);
        end
    end
endmodule

/* File: tb/test_modbus_exception_and_password_guard.sv */
// Self-checking bench for the request checker and password guard
`timescale 1ns/1ps
module test_modbus_exception_and_password_guard;
    logic clk = 1'b0, nrst = 1'b0, rv = 1'b0, re = 1'b0, rb = 1'b0, cv = 1'b0, ci = 1'b0;
    logic cn = 1'b0, hw = 1'b0, pv = 1'b0, clr = 1'b0, stall = 1'b0;
    logic [7:0] rs = 8'h00, rf = 8'h00;
    logic [10:0] flt = 11'h000;
    logic [3:0] cp = 4'h0;
    logic [31:0] cw = 32'h0, pa = 32'h0, pn = 32'h0;
    logic [1:0] pp = 2'h0;
    logic nr, tv, tl, tr, ce, cr, pd, pe, eb;
    logic [7:0] td;
    logic [15:0] cnt;
    int n_errors = 0, total_checks = 0, base = 0, n0;
    int n_nr = 0, n_ex = 0, n_rj = 0, n_dn = 0, n_er = 0, n_ls = 0;
    logic [18:0] rows [0:11] = '{19'h00101, 19'h00202, 19'h00402, 19'h00803, 19'h01004,
        19'h02005, 19'h04006, 19'h08007, 19'h10008, 19'h2000A, 19'h4000B, 19'h00000};
    logic [7:0] bad [0:3] = '{8'h2F, 8'h3A, 8'h5B, 8'h7B};
    always #5 clk = !clk;
    modbus_exception_and_password_guard modbus_exception_and_password_guard_inst (
        .CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(rv), .REQ_COMM_ERR_I(re),
        .REQ_BROADCAST_I(rb), .REQ_SLAVE_I(rs), .REQ_FUNC_I(rf), .FLT_ILL_FUNC_I(flt[0]),
        .FLT_ILL_ADDR_I(flt[1]), .FLT_REG_ABSENT_I(flt[2]), .FLT_ILL_VALUE_I(flt[3]),
        .FLT_DEV_FAIL_I(flt[4]), .FLT_LONG_I(flt[5]), .FLT_BUSY_I(flt[6]), .FLT_PROG_I(flt[7]),
        .FLT_PARITY_I(flt[8]), .FLT_GW_PATH_I(flt[9]), .FLT_GW_TARGET_I(flt[10]),
        .CMD_VALID_I(cv), .CMD_VIA_IFACE_I(ci), .CMD_INTRUSIVE_I(cn), .CMD_PROFILES_I(cp),
        .CMD_PASSWORD_I(cw), .HW_UNLOCKED_I(hw), .PWC_VALID_I(pv), .PWC_PROFILE_I(pp),
        .PWC_AUTH_I(pa), .PWC_NEW_I(pn), .CNT_CLEAR_I(clr), .TX_READY_I(tr),
        .NORMAL_RESP_O(nr), .EXC_BUSY_O(eb), .TX_VALID_O(tv), .TX_DATA_O(td), .TX_LAST_O(tl),
        .CMD_EXEC_O(ce), .CMD_REJECT_O(cr), .PWC_DONE_O(pd), .PWC_ERR_O(pe), .EXC_COUNT_O(cnt));
    bus_sink bus_sink_inst (.clk_i(clk), .nrst_i(nrst), .stall_i(stall), .tx_valid_i(tv),
        .tx_data_i(td), .tx_ready_o(tr));
    // ----------------------------------------
    // Pulse tallies and shared tasks
    // ----------------------------------------
    always @(posedge clk)
    begin
        n_nr += (nr === 1'b1);
        n_ex += (ce === 1'b1);
        n_rj += (cr === 1'b1);
        n_dn += (pd === 1'b1);
        n_er += (pe === 1'b1);
        n_ls += (tv === 1'b1 && tr === 1'b1 && tl === 1'b1);
    end
    task automatic complete_run;
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input logic [7:0] s, input logic [10:0] f, input logic e, input logic b);
        @(negedge clk);
        {rv, rs, flt, re, rb} = {1'b1, s, f, e, b};
        @(negedge clk);
        rv = 1'b0;
    endtask
    task automatic frame(input logic [7:0] s, input logic [7:0] f, input logic [7:0] c);
        for (int i = 0; bus_sink_inst.n_r < base + 5; i++)
        begin
            if (i == 200)
            begin
                n_errors++;
                complete_run();
            end
            @(negedge clk);
        end
        chk("slave", s, bus_sink_inst.rx_r[0]);
        chk("function", f | 8'h80, bus_sink_inst.rx_r[1]);
        chk("code", c, bus_sink_inst.rx_r[2]);
        chk("crc", 0, bus_sink_inst.res_r);
        chk("last", base / 5 + 1, n_ls);
        base = bus_sink_inst.n_r;
    endtask
    task automatic cmd(input logic i, input logic t, input logic [3:0] p,
        input logic [31:0] w, input logic x);
        int e0 = n_ex;
        int r0 = n_rj;
        @(negedge clk);
        {cv, ci, cn, cp, cw} = {1'b1, i, t, p, w};
        @(negedge clk);
        cv = 1'b0;
        repeat (2) @(negedge clk);
        chk("exec", e0 + x, n_ex);
        chk("reject", r0 + !x, n_rj);
    endtask
    task automatic pwc(input logic [1:0] p, input logic [31:0] a, input logic [31:0] w,
        input logic x);
        int d0 = n_dn;
        int f0 = n_er;
        @(negedge clk);
        {pv, pp, pa, pn} = {1'b1, p, a, w};
        @(negedge clk);
        pv = 1'b0;
        repeat (2) @(negedge clk);
        chk("done", d0 + x, n_dn);
        chk("refused", f0 + !x, n_er);
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        hw = 1'b1;
        chk("count", 0, cnt);
        for (int k = 0; k < 12; k++)
        begin
            n0 = n_nr;
            stall = k[0];
            rf = 8'(k + 1);
            req(8'(247 - k), rows[k][18:8], 1'b0, 1'b0);
            if (k < 11)
                frame(8'(247 - k), rf, rows[k][7:0]);
            repeat (3) @(negedge clk);
            chk("normal", n0 + (k == 11), n_nr);
            chk("count", k < 11 ? k + 1 : 11, cnt);
        end
        n0 = n_nr;
        req(8'h2F, 11'h000, 1'b1, 1'b0);
        req(8'h2F, 11'h001, 1'b1, 1'b0);
        req(8'h00, 11'h000, 1'b0, 1'b0);
        req(8'hF8, 11'h002, 1'b0, 1'b0);
        req(8'h2F, 11'h001, 1'b0, 1'b1);
        repeat (4) @(negedge clk);
        chk("silent normal", n0, n_nr);
        chk("silent bytes", base, bus_sink_inst.n_r);
        chk("count", 12, cnt);
        stall = 1'b1;
        rf = 8'h10;
        req(8'h2F, 11'h001, 1'b0, 1'b0);
        req(8'h2F, 11'h002, 1'b0, 1'b0);
        chk("busy", 1, eb);
        frame(8'h2F, 8'h10, 8'h01);
        repeat (4) @(negedge clk);
        chk("dropped", base, bus_sink_inst.n_r);
        chk("idle", 0, eb);
        req(8'h2F, 11'h002, 1'b0, 1'b0);
        frame(8'h2F, 8'h10, 8'h02);
        chk("count", 14, cnt);
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        chk("cleared", 0, cnt);
        cmd(1'b0, 1'b0, 4'h0, 32'h0, 1'b0);
        cmd(1'b1, 1'b0, 4'h0, 32'h0, 1'b1);
        for (int p = 0; p < 4; p++)
            cmd(1'b1, 1'b1, 4'h1 << p, {4{8'(8'h30 + p)}}, 1'b1);
        cmd(1'b1, 1'b1, 4'h2, 32'h30303030, 1'b0);
        hw = 1'b0;
        // Let the lock pad pass its two sync stages
        repeat (2) @(negedge clk);
        cmd(1'b1, 1'b1, 4'h2, 32'h31313131, 1'b0);
        hw = 1'b1;
        pwc(2'h3, 32'h33333333, 32'h4162397A, 1'b1);
        cmd(1'b1, 1'b1, 4'h8, 32'h4162397A, 1'b1);
        cmd(1'b1, 1'b1, 4'h8, 32'h33333333, 1'b0);
        pwc(2'h2, 32'h31313131, 32'h41424344, 1'b0);
        pwc(2'h2, 32'h30303030, 32'h7A5A3039, 1'b1);
        cmd(1'b1, 1'b1, 4'h4, 32'h7A5A3039, 1'b1);
        for (int j = 0; j < 4; j++)
            pwc(2'h1, 32'h31313131, {24'h313131, bad[j]}, 1'b0);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        cmd(1'b1, 1'b1, 4'h8, 32'h33333333, 1'b1);
        complete_run();
    end
endmodule
